// ### cold_load_pkg.sv
/*
 * constants for the cold load pickup and fast curve sequencing block:
 * register offsets, field positions, reset values and the interval timing.
 * assumes a 250 MHz core clock and a 60 Hz power system.
 */
package cold_load_pkg;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIVERSITY = 8'h04;
  localparam logic [7:0] OFS_NATURAL = 8'h08;
  localparam logic [7:0] OFS_FORCED = 8'h0c;
  localparam logic [7:0] OFS_PICKUP = 8'h10;
  localparam logic [7:0] OFS_GROUND = 8'h14;
  localparam logic [7:0] OFS_RECLOSE1 = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int CTL_PHASE_COLD = 0;
  localparam int CTL_GROUND_COLD = 1;
  localparam int CTL_RECLOSE_EN = 2;
  localparam int CTL_RESTORE_LO = 3; // phase, ground, sef restore enables
  localparam int CTL_TRIPS_LO = 8; // trip operations to lockout, 3 bits
  localparam int CTL_PFAST_LO = 12; // phase fast curve operation count
  localparam int CTL_GFAST_LO = 16; // ground fast curve operation count
  localparam logic [31:0] CTRL_RST = 32'h0002_2504;
  // ************************************************************
  // reset values and thresholds
  // ************************************************************
  localparam logic [15:0] DELAY_RST = 16'h0004;
  localparam logic [31:0] PICKUP_RST = 32'h0002_0064;
  localparam logic [15:0] GROUND_RST = 16'h00c8;
  localparam logic [15:0] RECLOSE1_RST = 16'h0001;
  localparam logic [15:0] NEUTRAL_LIMIT_MA = 16'h0064; // 0.1 A secondary
  localparam logic [2:0] MAX_SHOT = 3'h4;
  // ************************************************************
  // processing interval: one quarter of a power system cycle
  // ************************************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int SYSTEM_HZ = 60;
  localparam int INTERVALS_PER_CYCLE = 4;
  localparam int INTERVAL_CLKS = CLK_HZ / (SYSTEM_HZ * INTERVALS_PER_CYCLE);
  localparam int GROUPS = 3; // phase, ground, sef
endpackage

// ### cold_load_fast_curve_ctrl.sv
/*
 * cold load pickup latches, return timers and shot state tracking for a
 * recloser control, with a classic wishbone register slave.
 * assumes breaker status, reclosing sequencer states and element pickups
 * are synchronous to clk_i; the sequencer pulses reclose_issue_i just
 * before each reclose and keeps it for exactly one processing interval.
 */
`timescale 1ns/10ps
// What this block does
// - diversity timer enabled by phase or ground
// - diversity timer runs open and locked out
// - defeated reclosing zeroes reset, cycle, lockout states
// - timer expiry sets diversity lost for groups
// - diversity lost seals in phase engaged latch
// - engaged phase latch blocks fast curve
// - engaged phase delay curve follows cold instantaneous
// - natural return releases latch after timer
// - forced timer starts closed with restore enabled
// - forced return releases if restore enabled
// - ground return uses neutral below 0.1 A
// - ground enable drives ground and sef latches
// - one shot bit at a time
// - shot advances just before each reclose
// - fewer trips limit highest shot reached
// - phase fast permit for shots below count
// - ground fast permit built the same way
// - neutral fast ground chosen when more sensitive
// - defeated reclosing clears shots, enables fast curves with a nonzero count
// - logic evaluated once per quarter cycle
module cold_load_fast_curve_ctrl
  import cold_load_pkg::*;
#(
  parameter int TICK_CLKS = INTERVAL_CLKS,
  parameter int TW = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // breaker and reclosing sequencer
  input wire logic breaker_closed_i,
  input wire logic reclose_lockout_state_i,
  input wire logic reclose_reset_state_i,
  input wire logic reclose_cycle_state_i,
  input wire logic reclose_issue_i,
  output logic reclose_lockout_state_o,
  output logic reclose_reset_state_o,
  output logic reclose_cycle_state_o,
  // element pickups
  input wire logic phase_cold_inst_i,
  input wire logic ground_cold_inst_i,
  input wire logic phase_return_inst_i,
  input wire logic neutral_return_inst_i,
  input wire logic residual_return_inst_i,
  input wire logic sef_return_inst_i,
  // torque controls and status
  output logic phase_fast_torque_o,
  output logic phase_delay_torque_o,
  output logic ground_fast_torque_o,
  output logic ground_delay_torque_o,
  output logic sef_torque_o,
  output logic neutral_fast_ground_o,
  output logic residual_fast_ground_o,
  output logic [23:0] phase_cold_pickup_o,
  output logic [4:0] shot_o,
  output logic phase_fast_permit_o,
  output logic ground_fast_permit_o,
  output logic diversity_lost_o,
  output logic [2:0] cold_engaged_o
);
  // ************************************************************
  // registers and state
  // ************************************************************
  logic [31:0] ctrl_r;
  logic [TW-1:0] div_delay_r;
  logic [TW-1:0] nat_delay_r;
  logic [TW-1:0] frc_delay_r;
  logic [31:0] pickup_r;
  logic [15:0] gnd_min_r;
  logic [15:0] reclose1_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [TW-1:0] div_cnt_r;
  logic [TW-1:0] frc_cnt_r;
  logic [TW-1:0] nat_cnt_r [GROUPS];
  logic [2:0] engaged_r;
  logic [2:0] shot_r;
  logic [23:0] cold_pu_r;

  // ************************************************************
  // settings decode
  // ************************************************************
  wire phase_cold_enable = ctrl_r[CTL_PHASE_COLD];
  wire ground_cold_enable = ctrl_r[CTL_GROUND_COLD];
  wire reclosing_enable_setting = ctrl_r[CTL_RECLOSE_EN];
  wire [2:0] restore_en = ctrl_r[CTL_RESTORE_LO +: 3];
  wire [2:0] trip_ops = ctrl_r[CTL_TRIPS_LO +: 3];
  wire [2:0] phase_op_count = ctrl_r[CTL_PFAST_LO +: 3];
  wire [2:0] ground_op_count = ctrl_r[CTL_GFAST_LO +: 3];
  // reclosing counts as absent with no first interval or when switched off
  wire defeated = (reclose1_r == 16'h0000) || !reclosing_enable_setting;
  // ground and sef share one enable since they see the same zero sequence
  wire [2:0] group_en = {ground_cold_enable, ground_cold_enable, phase_cold_enable};
  // the neutral channel resolves small settings that the phase inputs cannot
  wire use_neutral = gnd_min_r < NEUTRAL_LIMIT_MA;
  wire ground_return = use_neutral ? neutral_return_inst_i : residual_return_inst_i;
  wire [2:0] return_inst = {sef_return_inst_i, ground_return, phase_return_inst_i};

  // ************************************************************
  // wishbone slave
  // ************************************************************
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wb_wr = wb_req && wb_we_i;
  wire hit_ctrl = wb_adr_i == OFS_CTRL;
  wire hit_div = wb_adr_i == OFS_DIVERSITY;
  wire hit_nat = wb_adr_i == OFS_NATURAL;
  wire hit_frc = wb_adr_i == OFS_FORCED;
  wire hit_pu = wb_adr_i == OFS_PICKUP;
  wire hit_gnd = wb_adr_i == OFS_GROUND;
  wire hit_rc1 = wb_adr_i == OFS_RECLOSE1;
  wire hit_stat = wb_adr_i == OFS_STATUS;
  wire [31:0] status_word = {10'h000, shot_o, ground_fast_permit_o, phase_fast_permit_o,
                             defeated, diversity_lost_o, 10'h000, engaged_r};
  // unmapped addresses read as zero and ignore writes
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_div ? 32'(div_delay_r) :
                       hit_nat ? 32'(nat_delay_r) :
                       hit_frc ? 32'(frc_delay_r) :
                       hit_pu ? pickup_r :
                       hit_gnd ? {16'h0000, gnd_min_r} :
                       hit_rc1 ? {16'h0000, reclose1_r} :
                       hit_stat ? status_word : 32'h0000_0000;

  // byte lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = din[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      rdata_r <= rd_mux;
    end
  end

  // settings registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      div_delay_r <= TW'(DELAY_RST);
      nat_delay_r <= TW'(DELAY_RST);
      frc_delay_r <= TW'(DELAY_RST);
      pickup_r <= PICKUP_RST;
      gnd_min_r <= GROUND_RST;
      reclose1_r <= RECLOSE1_RST;
    end else if (wb_wr) begin
      if (hit_ctrl) ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
      if (hit_div) div_delay_r <= TW'(merge(32'(div_delay_r), wb_dat_i, wb_sel_i));
      if (hit_nat) nat_delay_r <= TW'(merge(32'(nat_delay_r), wb_dat_i, wb_sel_i));
      if (hit_frc) frc_delay_r <= TW'(merge(32'(frc_delay_r), wb_dat_i, wb_sel_i));
      if (hit_pu) pickup_r <= merge(pickup_r, wb_dat_i, wb_sel_i);
      if (hit_gnd) gnd_min_r <= 16'(merge({16'h0000, gnd_min_r}, wb_dat_i, wb_sel_i));
      if (hit_rc1) reclose1_r <= 16'(merge({16'h0000, reclose1_r}, wb_dat_i, wb_sel_i));
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ************************************************************
  // processing interval tick
  // ************************************************************
  // every timer and latch below moves only on this tick
  assign tick = tick_cnt_r == 32'(TICK_CLKS - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  // ************************************************************
  // loss of load diversity and forced return timers
  // ************************************************************
  wire div_run = (phase_cold_enable || ground_cold_enable)
                 && !breaker_closed_i && (reclose_lockout_state_i || defeated);
  wire diversity_lost = div_run && (div_cnt_r >= div_delay_r);
  wire frc_run = breaker_closed_i && (restore_en != 3'h0);
  wire forced_return_done = frc_run && (frc_cnt_r >= frc_delay_r);

  // timers clear on the next tick after their run condition drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r <= '0;
      frc_cnt_r <= '0;
    end else if (tick) begin
      div_cnt_r <= !div_run ? '0 : (diversity_lost ? div_cnt_r : div_cnt_r + TW'(1));
      frc_cnt_r <= !frc_run ? '0 : (forced_return_done ? frc_cnt_r : frc_cnt_r + TW'(1));
    end
  end

  // ************************************************************
  // seal-in latches with natural and forced release
  // ************************************************************
  logic [2:0] nat_run;
  logic [2:0] natural_return_done;
  logic [2:0] release_c;
  logic [2:0] set_c;
  always_comb begin
    for (int g = 0; g < GROUPS; g++) begin
      nat_run[g] = breaker_closed_i && !return_inst[g];
      natural_return_done[g] = nat_run[g] && (nat_cnt_r[g] >= nat_delay_r);
      release_c[g] = natural_return_done[g] || (forced_return_done && restore_en[g]);
      set_c[g] = diversity_lost && group_en[g];
    end
  end

  // release checked first so it wins over a simultaneous set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      engaged_r <= 3'h0;
      for (int g = 0; g < GROUPS; g++) nat_cnt_r[g] <= '0;
    end else if (tick) begin
      for (int g = 0; g < GROUPS; g++) begin
        nat_cnt_r[g] <= !nat_run[g] ? '0 : (natural_return_done[g] ? nat_cnt_r[g] : nat_cnt_r[g] + TW'(1));
        if (release_c[g]) begin
          engaged_r[g] <= 1'b0;
        end else if (set_c[g]) begin
          engaged_r[g] <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // shot counter
  // ************************************************************
  // five trips give four reclosures; fewer trips cap the count lower
  wire [2:0] shot_cap = (trip_ops == 3'h0) ? 3'h0 :
                        (trip_ops > 3'h5) ? MAX_SHOT : trip_ops - 3'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shot_r <= 3'h0;
    end else if (tick) begin
      if (defeated || reclose_reset_state_i) begin
        shot_r <= 3'h0;
      end else if (reclose_issue_i && shot_r < shot_cap) begin
        shot_r <= shot_r + 3'h1;
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // one-hot decode, all zero while reclosing is absent
  assign shot_o = defeated ? 5'h00 : 5'(5'h01 << shot_r);
  assign phase_fast_permit_o = defeated ? (phase_op_count != 3'h0) : (shot_r < phase_op_count);
  assign ground_fast_permit_o = defeated ? (ground_op_count != 3'h0) : (shot_r < ground_op_count);
  assign reclose_lockout_state_o = reclose_lockout_state_i && !defeated;
  assign reclose_reset_state_o = reclose_reset_state_i && !defeated;
  assign reclose_cycle_state_o = reclose_cycle_state_i && !defeated;
  assign phase_fast_torque_o = phase_fast_permit_o && !engaged_r[0];
  assign phase_delay_torque_o = !engaged_r[0] || phase_cold_inst_i;
  assign ground_fast_torque_o = ground_fast_permit_o && !engaged_r[1];
  assign ground_delay_torque_o = !engaged_r[1] || ground_cold_inst_i;
  assign sef_torque_o = !engaged_r[2] || ground_cold_inst_i;
  assign neutral_fast_ground_o = ground_fast_torque_o && use_neutral;
  assign residual_fast_ground_o = ground_fast_torque_o && !use_neutral;
  assign diversity_lost_o = diversity_lost;
  assign cold_engaged_o = engaged_r;
  assign phase_cold_pickup_o = cold_pu_r;

  // raised pickup only; the delay curve shape is left alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cold_pu_r <= 24'h00_0000;
    end else begin
      cold_pu_r <= 24'(pickup_r[15:0]) * 24'(pickup_r[23:16]);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_FAST_BLOCKED: assert property (engaged_r[0] |-> !phase_fast_torque_o)
    else $error("phase fast curve enabled while cold load engaged");
  AST_DELAY_GATED: assert property (engaged_r[0] |-> phase_delay_torque_o == phase_cold_inst_i)
    else $error("phase delay torque not following cold instantaneous");
  AST_ONE_SHOT: assert property (!defeated |-> $onehot(shot_o))
    else $error("shot state not one-hot");
  AST_DEFEATED: assert property (defeated |-> shot_o == 5'h00 && !reclose_lockout_state_o
                                 && !reclose_cycle_state_o && !reclose_reset_state_o)
    else $error("reclosing states active while defeated");
  AST_RELEASE_WINS: assert property (tick && release_c[0] |=> !engaged_r[0])
    else $error("phase latch not released");
  AST_SEAL_IN: assert property (tick && set_c[0] && !release_c[0] |=> engaged_r[0] ##1 engaged_r[0])
    else $error("phase latch failed to seal in");
  AST_SHOT_STEP: assert property (tick && !defeated && !reclose_reset_state_i && reclose_issue_i
                                  && shot_r < shot_cap |=> shot_r == $past(shot_r) + 3'h1)
    else $error("shot did not advance before reclose");
  AST_SHOT_CAP: assert property (trip_ops != 3'h0 && trip_ops <= 3'h5 |-> shot_r < trip_ops)
    else $error("shot beyond configured trips");
  AST_PERMIT: assert property (!defeated |-> phase_fast_permit_o == (shot_r < phase_op_count))
    else $error("phase fast permit mismatch");
  AST_NO_DIVERSITY_CLOSED: assert property (breaker_closed_i |-> !diversity_lost)
    else $error("diversity lost with breaker closed");
  AST_WB_ACK: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o) // bus handshake
    else $error("wishbone ack not a single cycle");

  COV_ENGAGE: cover property (tick && set_c[0] ##1 engaged_r[0]);
  COV_NATURAL: cover property (tick && natural_return_done[0] && engaged_r[0]);
  COV_FORCED: cover property (tick && forced_return_done && engaged_r[1]);
  COV_SHOT_FOUR: cover property (shot_o[4]);
endmodule

// ### recloser_seq_model.sv
/*
 * breaker and reclosing sequencer model standing beside the cold load block.
 * assumes one bench process calls its tasks, each starting on a clock edge.
 */
`timescale 1ns/10ps
module recloser_seq_model #(
  parameter int HOLD_CLKS = 4
) (
  // clock
  input wire logic clk_i,
  // breaker and sequencer states
  output logic breaker_closed_o,
  output logic lockout_o,
  output logic reset_st_o,
  output logic cycle_st_o,
  output logic issue_o
);
  // ************************************************************
  // idle: breaker closed, sequencer at reset
  // ************************************************************
  initial begin
    breaker_closed_o = 1'b1;
    lockout_o = 1'b0;
    reset_st_o = 1'b1;
    cycle_st_o = 1'b0;
    issue_o = 1'b0;
  end
  // breaker opens, sequencer either cycling or locked out
  task automatic trip(input logic lock);
    @(posedge clk_i);
    breaker_closed_o <= 1'b0;
    lockout_o <= lock;
    cycle_st_o <= ~lock;
    reset_st_o <= 1'b0;
  endtask
  // issue spans exactly one tick so the shot advances once
  task automatic reclose();
    @(posedge clk_i);
    issue_o <= 1'b1;
    repeat (HOLD_CLKS) @(posedge clk_i);
    issue_o <= 1'b0;
    breaker_closed_o <= 1'b1;
  endtask
  // breaker closed and sequencer back at reset
  task automatic rearm();
    @(posedge clk_i);
    breaker_closed_o <= 1'b1;
    lockout_o <= 1'b0;
    cycle_st_o <= 1'b0;
    reset_st_o <= 1'b1;
    repeat (HOLD_CLKS) @(posedge clk_i);
  endtask
endmodule

// ### tb_cold_load_fast_curve_ctrl.sv
/*
 * self-checking bench for the cold load and fast curve block.
 * assumes the package and the sequencer model are compiled first.
 */
`timescale 1ns/10ps
module tb_cold_load_fast_curve_ctrl
  import cold_load_pkg::*;
;
  typedef struct {logic [2:0] pf; logic [2:0] gf; logic [2:0] trips; int adv;} row_t;
  localparam int LIM = 200;
  // pickups: cold phase, cold ground, phase, neutral, residual, sef return
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [5:0] pick = 6'h0;
  logic [3:0] lanes = 4'hf;
  logic wb_ack_o, brk, lock_st, rst_st, cyc_st, issue, lo_o, rs_o, cy_o, pft, pdt, gft, gdt, sft, nfg, rfg;
  logic pperm, gperm, div_lost;
  logic [23:0] cold_pu;
  logic [4:0] shot_o;
  logic [2:0] cold_engaged_o;
  int error_cnt = 0, n_tests = 0, j, s;
  row_t rows[9] = '{'{3'h2, 3'h2, 3'h5, 0}, '{3'h2, 3'h2, 3'h5, 1}, '{3'h2, 3'h3, 3'h5, 2},
    '{3'h1, 3'h4, 3'h5, 3}, '{3'h0, 3'h5, 3'h5, 4}, '{3'h5, 3'h2, 3'h5, 6}, '{3'h3, 3'h1, 3'h3, 4},
    '{3'h4, 3'h0, 3'h4, 5}, '{3'h1, 3'h3, 3'h2, 3}};
  always #2 clk_i = ~clk_i;
  // ************************************************************
  // partner and design
  // ************************************************************
  recloser_seq_model seq_u (.clk_i(clk_i), .breaker_closed_o(brk), .lockout_o(lock_st),
    .reset_st_o(rst_st), .cycle_st_o(cyc_st), .issue_o(issue));
  cold_load_fast_curve_ctrl #(.TICK_CLKS(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .breaker_closed_i(brk),
    .reclose_lockout_state_i(lock_st), .reclose_reset_state_i(rst_st), .reclose_cycle_state_i(cyc_st),
    .reclose_issue_i(issue), .reclose_lockout_state_o(lo_o), .reclose_reset_state_o(rs_o),
    .reclose_cycle_state_o(cy_o), .phase_cold_inst_i(pick[5]), .ground_cold_inst_i(pick[4]),
    .phase_return_inst_i(pick[3]), .neutral_return_inst_i(pick[2]), .residual_return_inst_i(pick[1]),
    .sef_return_inst_i(pick[0]), .phase_fast_torque_o(pft), .phase_delay_torque_o(pdt),
    .ground_fast_torque_o(gft), .ground_delay_torque_o(gdt), .sef_torque_o(sft), .neutral_fast_ground_o(nfg),
    .residual_fast_ground_o(rfg), .phase_cold_pickup_o(cold_pu), .shot_o(shot_o), .phase_fast_permit_o(pperm),
    .ground_fast_permit_o(gperm), .diversity_lost_o(div_lost), .cold_engaged_o(cold_engaged_o));
  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a wait that used up its bound ends the run
  task automatic tmo(input int i);
    if (i >= LIM) begin
      error_cnt++;
      $display("unexpected wait: expected an answer within %0d cycles, seen none", LIM);
      end_sim();
    end
  endtask
  // classic wishbone cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= lanes;
    wb_dat_i <= wd;
    for (i = 0; i < LIM; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    tmo(i);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] x;
    wb_xfer(1'b1, adr, d, x);
  endtask
  task automatic rdc(input string nm, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] x;
    wb_xfer(1'b0, adr, 32'h0, x);
    chk(nm, exp, x);
  endtask
  // tick spacing is fixed by the tick parameter, four clocks here
  task automatic ticks(input int n);
    repeat (n * 4) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_eng(input logic [2:0] exp);
    int i;
    for (i = 0; i < LIM; i++) begin
      @(posedge clk_i);
      if (cold_engaged_o === exp) break;
    end
    #1;
    tmo(i);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    ticks(1);
    chk("shot", 32'h1, 32'(shot_o));
    chk("engaged", 32'h0, 32'(cold_engaged_o));
    rdc("ctrl", OFS_CTRL, CTRL_RST);
    rdc("pickup", OFS_PICKUP, PICKUP_RST);
    wr(8'h24, 32'hffff_ffff);
    rdc("unmapped", 8'h24, 32'h0);
    // only the second byte lane is written
    lanes = 4'h2;
    wr(OFS_GROUND, 32'hffff_01ff);
    lanes = 4'hf;
    rdc("byte lanes", OFS_GROUND, 32'h1c8);
    chk("cold pickup", 32'hc8, 32'(cold_pu));
    // shot tracking and fast permits, one row per case
    foreach (rows[k]) begin
      // back to shot zero first, so a lower trip count never sees a higher shot
      seq_u.rearm();
      wr(OFS_CTRL, 32'h4 | {13'h0, rows[k].gf, 1'b0, rows[k].pf, 1'b0, rows[k].trips, 8'h0});
      for (j = 0; j < rows[k].adv; j++) begin
        seq_u.trip(1'b0);
        seq_u.reclose();
      end
      ticks(2);
      s = (rows[k].adv < rows[k].trips - 1) ? rows[k].adv : rows[k].trips - 1;
      chk("shot", 32'h1 << s, 32'(shot_o));
      chk("permits", {30'h0, s < rows[k].pf, s < rows[k].gf}, {30'h0, pperm, gperm});
    end
    // defeated by a zero first interval, then by the enable bit
    wr(OFS_CTRL, CTRL_RST);
    seq_u.trip(1'b1);
    wr(OFS_RECLOSE1, 32'h0);
    ticks(1);
    chk("shot", 32'h0, 32'(shot_o));
    chk("permits", 32'h3, {30'h0, pperm, gperm});
    chk("states", 32'h0, {29'h0, lo_o, rs_o, cy_o});
    wr(OFS_RECLOSE1, 32'h1);
    wr(OFS_CTRL, CTRL_RST & ~32'h4);
    ticks(1);
    chk("shot", 32'h0, 32'(shot_o));
    wr(OFS_CTRL, CTRL_RST);
    ticks(8);
    chk("diversity", 32'h0, 32'(div_lost));
    seq_u.rearm();
    wr(OFS_CTRL, CTRL_RST | 32'h3);
    ticks(8);
    chk("diversity", 32'h0, 32'(div_lost));
    // engage all three groups, then desensitised curves
    seq_u.trip(1'b1);
    wait_eng(3'h7);
    chk("states", 32'h4, {29'h0, lo_o, rs_o, cy_o});
    chk("diversity", 32'h1, 32'(div_lost));
    chk("fast torque", 32'h0, {30'h0, pft, gft});
    chk("delay torque", 32'h0, 32'(pdt));
    @(posedge clk_i);
    pick <= 6'h2f;
    #1;
    chk("delay torque", 32'h1, 32'(pdt));
    chk("ground delay torque", 32'h0, {30'h0, gdt, sft});
    @(posedge clk_i);
    pick <= 6'h1f;
    #1;
    chk("ground delay torque", 32'h3, {30'h0, gdt, sft});
    chk("delay torque", 32'h0, 32'(pdt));
    wr(OFS_PICKUP, 32'h0003_0050);
    ticks(1);
    chk("cold pickup", 32'hf0, 32'(cold_pu));
    // natural return for phase, then ground; ground watches neutral below 100 ma
    wr(OFS_GROUND, 32'h32);
    @(posedge clk_i);
    pick <= 6'h07;
    seq_u.rearm();
    wait_eng(3'h6);
    @(posedge clk_i);
    pick <= 6'h05;
    ticks(10);
    chk("engaged", 32'h6, 32'(cold_engaged_o));
    @(posedge clk_i);
    pick <= 6'h03;
    wait_eng(3'h4);
    // forced return releases only groups with restore enabled
    wr(OFS_FORCED, 32'h2);
    wr(OFS_CTRL, CTRL_RST | 32'hb);
    ticks(6);
    chk("engaged", 32'h4, 32'(cold_engaged_o));
    wr(OFS_CTRL, CTRL_RST | 32'h23);
    wait_eng(3'h0);
    chk("fast ground", 32'h2, {30'h0, nfg, rfg});
    wr(OFS_GROUND, 32'hc8);
    ticks(1);
    chk("fast ground", 32'h1, {30'h0, nfg, rfg});
    // re-engage, then reset in mid-run
    wr(OFS_CTRL, CTRL_RST | 32'h3);
    seq_u.trip(1'b1);
    wait_eng(3'h7);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("engaged", 32'h0, 32'(cold_engaged_o));
    chk("shot", 32'h1, 32'(shot_o));
    chk("diversity", 32'h0, 32'(div_lost));
    rdc("ctrl", OFS_CTRL, CTRL_RST);
    end_sim();
  end
endmodule
